// File: logic/smbep_regs.vh
// SMBus slave port constants: addresses, commands, memory map, timing.
// Assumes a 40 MHz system clock; included by the port only.
`ifndef SMBEP_REGS_VH
`define SMBEP_REGS_VH

`define SMBEP_ADDR_HIGH      4'hA
`define SMBEP_BCAST_ADDR     7'h0C
`define SMBEP_EXTEND_BIT     1
`define SMBEP_PIN_GND        2'h0
`define SMBEP_PIN_VDD        2'h1
`define SMBEP_PIN_FLOAT      2'h2
`define SMBEP_CMD_BLK_WR     8'hA0
`define SMBEP_CMD_BLK_RD     8'hA1
`define SMBEP_CMD_ERASE      8'hA2
`define SMBEP_EE_HI_FRU      8'h80
`define SMBEP_EE_HI_REG      8'h81
`define SMBEP_RAM_TOP        8'h7F
`define SMBEP_PAGE_BYTES     6'h20
`define SMBEP_EE_ERASED      8'hFF
`define SMBEP_REG_BREAK      7'h40
`define SMBEP_REG_DRIVE      7'h41
`define SMBEP_REG_RAW        7'h42
`define SMBEP_ERASE_TIME_US  20000
`define SMBEP_CLK_KHZ        40000
`define SMBEP_ERASE_CYCLES   ((`SMBEP_ERASE_TIME_US * `SMBEP_CLK_KHZ) / 1000)

`endif

// File: logic/smbep_port.v
// SMBus slave port: volatile registers, paged nonvolatile array, page erase.
// Assumes SCL and SDA arrive asynchronously from an open-drain bus.
`timescale 1ns/100ps
`default_nettype none
`include "smbep_regs.vh"

// What this block does
// (RL1) Answer slave address 1010 plus three low bits from pin and extend bit.
// (RL2) Ground/supply/float give 000/001/100, or 010/011/101 with extend set.
// (RL3) Extend bit resets low and is latched only at the nonvolatile download.
// (RL4) Data falling while clock high is a start condition.
// (RL5) After start shift seven address bits MSB first, then direction bit.
// (RL6) On match pull data low through the ninth clock as acknowledge.
// (RL7) Bytes are nine clocks; data moves only while clock is low.
// (RL8) First byte written after the address is the command byte.
// (RL9) Master sets pointer and read type with a write before reading.
// (RL10) Master ends a read with no-acknowledge, then a stop.
// (RL11) Master ends a write with data rising while clock high.
// (RL12) A repeated start begins a fresh address phase.
// (RL13) Registers sit at 00h-7Fh, nonvolatile memory from 8000h.
// (RL14) Broadcast address is also answered; only for write commands.
// (RL15) Nonvolatile bytes program only when erased; master erases first.
// (RL16) Command A2h followed by the page location erases a page.
// (RL17) Sixteen pages of 32 bytes; default page begins at 8100h.
// (RL18) Erase page is high byte plus top three low bits; rest ignored.
// (RL19) Erase lasts 20 ms; nonvolatile access meanwhile gets no-acknowledge.
// (RL20) Break bits hand power-on and mains paths to register values.
// (RL21) Host keeps the bus idle during configuration.
// (RL22) Commands 00h-7Fh write one register; 80h/81h set address and program.
// (RL23) Command A1h starts a block read of at most 32 bytes.
// (RL24) Address pin sampled continuously; bias released after first addressing.
// (RL25) Unmatched address leaves data released until the next start.
module smbep_port #(
    parameter ERASE_CYCLES = `SMBEP_ERASE_CYCLES
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       sclIn,
    input  wire       sdaIn,
    output wire       sdaOut,
    output reg        sdaOe,
    input  wire [1:0] addrPinState,
    output reg        addrBiasEn,
    input  wire [7:0] cfgWordFour,
    input  wire       cfgLoadDone,
    input  wire       powerOnRequestIn,
    input  wire       mainsSenseIn,
    output reg        powerOnRequestOut,
    output reg        mainsSenseOut,
    output wire       eraseBusy
);
    localparam ST_IDLE = 5'h01;
    localparam ST_RX   = 5'h02;
    localparam ST_RACK = 5'h04;
    localparam ST_TX   = 5'h08;
    localparam ST_TACK = 5'h10;
    localparam FW      = 10;

    reg  [5:0]  sync1_r;
    reg  [5:0]  sync2_r;
    reg         sclP_r;
    reg         sdaP_r;
    reg         extend_r;
    reg  [4:0]  st_r;
    reg  [3:0]  bitCnt_r;
    reg  [7:0]  shift_r;
    reg  [1:0]  byteIdx_r;
    reg         rdMode_r;
    reg         cmdEe_r;
    reg         sendCount_r;
    reg         ptrInc_r;
    reg  [15:0] ptr_r;
    reg  [7:0]  cmdQ_r;
    reg  [7:0]  eraseHi_r;
    reg         blkRd_r;
    reg  [1:0]  ctrlBreak_r;
    reg  [1:0]  ctrlDrive_r;
    reg  [19:0] eraseCnt_r;
    reg  [5:0]  eraseIdx_r;
    reg  [3:0]  erasePage_r;
    reg  [FW-1:0] fifo_r [0:1];
    reg  [1:0]  fCnt_r;
    reg         fRd_r;
    reg         fWr_r;
    reg  [7:0]  ram [0:127];
    reg  [7:0]  ee [0:511];
    reg  [2:0]  lowBits;
    reg  [7:0]  txByte;
    reg         ack;
    reg         ramWe;
    reg         eeWe;
    reg  [8:0]  eeAddr;
    reg  [7:0]  wData;
    integer     i;

    wire        sclS = sync2_r[5];
    wire        sdaS = sync2_r[4];
    wire [1:0]  pinS = sync2_r[3:2];
    wire        powerS = sync2_r[1];
    wire        mainsS = sync2_r[0];
    wire        sclRise = sclS & ~sclP_r;
    wire        sclFall = ~sclS & sclP_r;
    wire        startEv = sclS & sclP_r & sdaP_r & ~sdaS;
    wire        stopEv = sclS & sclP_r & ~sdaP_r & sdaS;
    wire [6:0]  myAddr = {`SMBEP_ADDR_HIGH, lowBits};
    wire        ptrEe = ptr_r[15];
    wire        wiping = eraseIdx_r < `SMBEP_PAGE_BYTES;
    wire        fillReady = (fCnt_r != 2'h2);
    wire        fValid = (fCnt_r != 2'h0);
    wire        drainReady = ~wiping;
    wire        push = st_r[1] & sclFall & (bitCnt_r == 4'h8) & (byteIdx_r != 2'h0) & ack;
    wire        pop = fValid & drainReady;
    wire [FW-1:0] head = fifo_r[fRd_r];
    wire [1:0]  hIdx = head[9:8];
    wire [7:0]  hData = head[7:0];
    wire [5:0]  blkCount = `SMBEP_PAGE_BYTES - {1'b0, ptr_r[4:0]};
    wire        shiftIsEe = (shift_r == `SMBEP_EE_HI_FRU) | (shift_r == `SMBEP_EE_HI_REG) |
                            (shift_r == `SMBEP_CMD_ERASE) |
                            (((shift_r == `SMBEP_CMD_BLK_WR) | (shift_r == `SMBEP_CMD_BLK_RD)) & ptrEe);

    assign sdaOut = 1'b0;
    assign eraseBusy = (eraseCnt_r != 20'h00000);

    // Every pin input passes two flops before use.
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : gSync
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_r[g] <= 1'b1;
                    sync2_r[g] <= 1'b1;
                end else begin
                    sync1_r[g] <= (g == 5) ? sclIn : (g == 4) ? sdaIn : (g == 3) ? addrPinState[1] :
                                  (g == 2) ? addrPinState[0] : (g == 1) ? powerOnRequestIn : mainsSenseIn;
                    sync2_r[g] <= sync1_r[g];
                end
            end
        end
    endgenerate

    // Low address bits from the live pin and the latched extend bit.
    always @* begin
        case (pinS)
            `SMBEP_PIN_VDD:   lowBits = {1'b0, extend_r, 1'b1};             // [RL2]
            `SMBEP_PIN_FLOAT: lowBits = extend_r ? 3'h5 : 3'h4;             // [RL2]
            default:          lowBits = {1'b0, extend_r, 1'b0};             // [RL2]
        endcase
    end

    // Next byte to send: block count first, then memory.
    always @* begin
        if (sendCount_r)
            txByte = {2'h0, blkCount};                                       // [RL23]
        else if (ptrEe)
            txByte = ee[ptr_r[8:0]];                                         // [RL13]
        else if (ptr_r[6:0] == `SMBEP_REG_BREAK)
            txByte = {6'h00, ctrlBreak_r};
        else if (ptr_r[6:0] == `SMBEP_REG_DRIVE)
            txByte = {6'h00, ctrlDrive_r};
        else if (ptr_r[6:0] == `SMBEP_REG_RAW)
            txByte = {6'h00, mainsS, powerS};                                // [RL20]
        else
            txByte = ram[ptr_r[6:0]];
    end

    // Acknowledge decision for the byte just shifted in.
    always @* begin
        if (byteIdx_r == 2'h0)
            ack = ((shift_r[7:1] == myAddr) & ~(shift_r[0] & eraseBusy & ptrEe)) | // [RL1] [RL19]
                  ((shift_r[7:1] == `SMBEP_BCAST_ADDR) & ~shift_r[0]);               // [RL14]
        else if (byteIdx_r == 2'h1)
            ack = fillReady & ~(eraseBusy & shiftIsEe);                     // [RL19]
        else
            ack = fillReady & ~(eraseBusy & cmdEe_r);                       // [RL19]
    end

    // Bus framing engine; the bus clock is only sampled, never stretched.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclP_r <= 1'b1;
            sdaP_r <= 1'b1;
            st_r <= ST_IDLE;
            bitCnt_r <= 4'h0;
            shift_r <= 8'h00;
            byteIdx_r <= 2'h0;
            rdMode_r <= 1'b0;
            cmdEe_r <= 1'b0;
            sendCount_r <= 1'b0;
            ptrInc_r <= 1'b0;
            sdaOe <= 1'b0;
            addrBiasEn <= 1'b1;
        end else begin
            sclP_r <= sclS;
            sdaP_r <= sdaS;
            ptrInc_r <= 1'b0;
            if (startEv) begin
                st_r <= ST_RX;                                               // [RL4] [RL12]
                bitCnt_r <= 4'h0;
                byteIdx_r <= 2'h0;
                sdaOe <= 1'b0;
            end else if (stopEv) begin
                st_r <= ST_IDLE;
                sdaOe <= 1'b0;
            end else begin
                case (st_r)
                    ST_RX: begin
                        if (sclRise) begin
                            shift_r <= {shift_r[6:0], sdaS};                 // [RL5] [RL7]
                            bitCnt_r <= bitCnt_r + 4'h1;
                        end else if (sclFall && bitCnt_r == 4'h8) begin
                            bitCnt_r <= 4'h0;
                            if (byteIdx_r == 2'h0) begin
                                rdMode_r <= shift_r[0];                      // [RL5]
                                sendCount_r <= blkRd_r & shift_r[0];         // [RL9]
                                if (ack)
                                    addrBiasEn <= 1'b0;                      // [RL24]
                            end
                            if (byteIdx_r == 2'h1)
                                cmdEe_r <= shiftIsEe;                        // [RL8]
                            st_r <= ack ? ST_RACK : ST_IDLE;                 // [RL25]
                            sdaOe <= ack;                                    // [RL6]
                        end
                    end
                    ST_RACK: begin
                        if (sclFall) begin
                            if (byteIdx_r != 2'h3)
                                byteIdx_r <= byteIdx_r + 2'h1;
                            if (rdMode_r) begin
                                st_r <= ST_TX;
                                shift_r <= txByte;
                                sdaOe <= ~txByte[7];
                                bitCnt_r <= 4'h1;
                                sendCount_r <= 1'b0;
                                ptrInc_r <= ~sendCount_r;
                            end else begin
                                st_r <= ST_RX;
                                sdaOe <= 1'b0;
                            end
                        end
                    end
                    ST_TX: begin
                        if (sclFall) begin
                            if (bitCnt_r == 4'h8) begin
                                sdaOe <= 1'b0;
                                st_r <= ST_TACK;
                            end else begin
                                sdaOe <= ~shift_r[6];                        // [RL7]
                                shift_r <= {shift_r[6:0], 1'b0};
                                bitCnt_r <= bitCnt_r + 4'h1;
                            end
                        end
                    end
                    ST_TACK: begin
                        if (sclRise && sdaS)
                            st_r <= ST_IDLE;                                 // [RL10]
                        else if (sclFall) begin
                            st_r <= ST_TX;
                            shift_r <= txByte;
                            sdaOe <= ~txByte[7];
                            bitCnt_r <= 4'h1;
                            ptrInc_r <= 1'b1;
                        end
                    end
                    ST_IDLE: begin
                        sdaOe <= 1'b0;
                    end
                    default: begin
                        st_r <= ST_IDLE;
                        sdaOe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Two-entry buffer from the framing engine to the command executor.
    // A full buffer refuses a byte with no-acknowledge: the clock cannot be held.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fCnt_r <= 2'h0;
            fRd_r <= 1'b0;
            fWr_r <= 1'b0;
        end else begin
            if (push) begin
                fWr_r <= ~fWr_r;
            end
            if (pop) begin
                fRd_r <= ~fRd_r;
            end
            fCnt_r <= fCnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    always @(posedge clk) begin
        if (push)
            fifo_r[fWr_r] <= {byteIdx_r - 2'h1, shift_r};
    end

    // Decode of the buffered byte into memory writes.
    always @* begin
        ramWe = 1'b0;
        eeWe = 1'b0;
        eeAddr = ptr_r[8:0];
        wData = hData;
        if (wiping) begin
            eeWe = 1'b1;
            eeAddr = {erasePage_r, eraseIdx_r[4:0]};
            wData = `SMBEP_EE_ERASED;
        end else if (pop && hIdx != 2'h0) begin
            if (cmdQ_r <= `SMBEP_RAM_TOP && hIdx == 2'h1)
                ramWe = 1'b1;                                                // [RL22]
            else if (((cmdQ_r == `SMBEP_EE_HI_FRU || cmdQ_r == `SMBEP_EE_HI_REG) && hIdx == 2'h2) ||
                     (cmdQ_r == `SMBEP_CMD_BLK_WR && hIdx != 2'h1)) begin
                ramWe = ~ptrEe;
                eeWe = ptrEe & (ee[ptr_r[8:0]] == `SMBEP_EE_ERASED);        // [RL15]
            end
        end
    end

    // Command executor: pointer, block mode, control bits and page erase.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_r <= 16'h0000;
            cmdQ_r <= 8'h00;
            eraseHi_r <= 8'h00;
            blkRd_r <= 1'b0;
            ctrlBreak_r <= 2'h0;
            ctrlDrive_r <= 2'h0;
            eraseCnt_r <= 20'h00000;
            eraseIdx_r <= `SMBEP_PAGE_BYTES;
            erasePage_r <= 4'h0;
            extend_r <= 1'b0;
        end else begin
            if (cfgLoadDone)
                extend_r <= cfgWordFour[`SMBEP_EXTEND_BIT];                 // [RL3]
            if (eraseBusy)
                eraseCnt_r <= eraseCnt_r - 20'h00001;
            if (wiping)
                eraseIdx_r <= eraseIdx_r + 6'h01;
            if (pop && hIdx == 2'h0) begin
                cmdQ_r <= hData;                                             // [RL8]
                blkRd_r <= (hData == `SMBEP_CMD_BLK_RD);                    // [RL23]
                if (hData <= `SMBEP_RAM_TOP)
                    ptr_r <= {8'h00, hData};                                 // [RL13]
            end else if (pop && hIdx == 2'h1 && (cmdQ_r == `SMBEP_EE_HI_FRU || cmdQ_r == `SMBEP_EE_HI_REG)) begin
                ptr_r <= {cmdQ_r, hData};                                    // [RL22]
            end else if (pop && hIdx == 2'h1 && cmdQ_r == `SMBEP_CMD_ERASE) begin
                eraseHi_r <= hData;                                          // [RL16]
            end else if (pop && hIdx == 2'h2 && cmdQ_r == `SMBEP_CMD_ERASE) begin
                if (eraseHi_r == `SMBEP_EE_HI_FRU || eraseHi_r == `SMBEP_EE_HI_REG) begin
                    erasePage_r <= {eraseHi_r[0], hData[7:5]};               // [RL17] [RL18]
                    eraseIdx_r <= 6'h00;
                    eraseCnt_r <= ERASE_CYCLES[19:0];                        // [RL19]
                end
            end else if ((ramWe || eeWe) && !wiping && cmdQ_r == `SMBEP_CMD_BLK_WR) begin
                ptr_r <= {ptr_r[15:5], ptr_r[4:0] + 5'h01};                  // [RL17]
            end else if (ptrInc_r) begin
                ptr_r <= {ptr_r[15:5], ptr_r[4:0] + 5'h01};                  // [RL23]
            end
            if (ramWe && ptr_r[6:0] == `SMBEP_REG_BREAK)
                ctrlBreak_r <= hData[1:0];                                   // [RL20]
            if (ramWe && ptr_r[6:0] == `SMBEP_REG_DRIVE)
                ctrlDrive_r <= hData[1:0];                                   // [RL20]
        end
    end

    // The array starts erased, all ones, so first programming is accepted.
    initial
        for (i = 0; i < 512; i = i + 1)
            ee[i] = `SMBEP_EE_ERASED;

    // Array storage has no reset.
    always @(posedge clk) begin
        if (ramWe)
            ram[ptr_r[6:0]] <= wData;
        if (eeWe)
            ee[eeAddr] <= wData;
    end

    // Broken paths take the register value, else the pin passes.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            powerOnRequestOut <= 1'b0;
            mainsSenseOut <= 1'b0;
        end else begin
            powerOnRequestOut <= ctrlBreak_r[0] ? ctrlDrive_r[0] : powerS;  // [RL20]
            mainsSenseOut <= ctrlBreak_r[1] ? ctrlDrive_r[1] : mainsS;      // [RL20]
        end
    end
endmodule // smbep_port
`default_nettype wire

// File: verif/smbep_port_sva.sv
// Checker for the SMBus slave port: pin timing, erase length, bias release.
// Sees only the port's pins; bound to every port instance.
`timescale 1ns/100ps
`default_nettype none
module smbep_port_sva #(
    parameter ERASE_CYCLES = 100
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOe,
    input wire logic addrBiasEn,
    input wire logic eraseBusy
);
    logic [31:0] busyCnt_r;
    logic        sdaIn_r;
    logic        startSeen_r;
    logic        oeSeen_r;

    // Raw pins: a start must be real on the wire.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busyCnt_r <= 32'h0;
            sdaIn_r <= 1'b1;
            startSeen_r <= 1'b0;
            oeSeen_r <= 1'b0;
        end else begin
            busyCnt_r <= eraseBusy ? busyCnt_r + 32'h1 : 32'h0;
            sdaIn_r <= sdaIn;
            startSeen_r <= startSeen_r | (sclIn & sdaIn_r & ~sdaIn);
            oeSeen_r <= oeSeen_r | sdaOe;
        end
    end

    // System clock; checks rest in reset.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_RESET_IDLE: assert property ($rose(rst_n) |-> !sdaOe && addrBiasEn && !eraseBusy)
        else $error("outputs not idle after reset");
    AST_OE_MOVES_SCL_LOW: assert property ($changed(sdaOe) |-> !sclIn && !$past(sclIn, 2))
        else $error("data pull-down changed while clock high");
    AST_ACK_HOLD: assert property ($rose(sdaOe) |-> sdaOe [*8])
        else $error("pull-down released too early");
    AST_OE_NEEDS_START: assert property (sdaOe |-> startSeen_r)
        else $error("pull-down without a start");
    AST_ERASE_LENGTH: assert property ($fell(eraseBusy) |-> busyCnt_r == ERASE_CYCLES)
        else $error("erase busy length wrong");
    AST_BUSY_BOUNDED: assert property (eraseBusy |-> busyCnt_r < ERASE_CYCLES)
        else $error("erase busy too long");
    AST_BIAS_STAYS_OFF: assert property (!addrBiasEn |=> !addrBiasEn)
        else $error("address bias came back");
    AST_BIAS_AFTER_ACK: assert property ($fell(addrBiasEn) |-> oeSeen_r || sdaOe)
        else $error("bias released before an acknowledge");
endmodule // smbep_port_sva

bind smbep_port smbep_port_sva #(.ERASE_CYCLES(ERASE_CYCLES)) i_smbep_port_sva (
    .clk(clk), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOe(sdaOe),
    .addrBiasEn(addrBiasEn), .eraseBusy(eraseBusy)
);
`default_nettype wire

// File: verif/smbep_master_model.sv
// SMBus master model: start, stop and nine-clock bytes.
// Assumes pull-ups; the bench wires sdaDrv with the port's pull-down.
`timescale 1ns/100ps
`default_nettype none
module smbep_master_model (
    input  wire logic clk,
    output var logic  sclOut,
    output var logic  sdaDrv,
    input  wire logic sdaWire
);
    int halfCycles = 8; // Cycles per bus clock phase.

    // Idle bus at time zero.
    initial begin
        sclOut = 1'b1;
        sdaDrv = 1'b1;
    end

    // One bus clock phase.
    task automatic phase();
        repeat (halfCycles) @(posedge clk);
    endtask

    // Start (b high) or stop (b low): data moves to ~b while the clock is high.
    task automatic cond(input logic b);
        @(posedge clk);
        sdaDrv <= b;
        phase();
        sclOut <= 1'b1;
        phase();
        sdaDrv <= ~b;
        phase();
        if (b)
            sclOut <= 1'b0;
    endtask

    // Data moves after the clock falls and is sampled mid-high.
    task automatic bitX(input logic b, output logic r);
        @(posedge clk);
        sdaDrv <= b;
        phase();
        sclOut <= 1'b1;
        repeat (halfCycles / 2) @(negedge clk);
        r = sdaWire;
        phase();
        sclOut <= 1'b0;
    endtask

    // Eight bits MSB first, then the ack slot; ackOut high if pulled low.
    task automatic byteX(input logic [7:0] d, input logic ackDrv, output logic [7:0] r, output logic ackOut);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bitX(d[i], a);
            r[i] = a;
        end
        bitX(ackDrv, a);
        ackOut = ~a;
    endtask
endmodule // smbep_master_model
`default_nettype wire

// File: verif/tb.sv
// Bench for the SMBus slave port: address, registers, pages, erase, break path.
// Assumes the master model and a pull-up on the data line.
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int ERASE = 600; // Short erase for a brief run.
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       sclIn;
    logic       sdaDrv;
    logic       sdaOe;
    logic [1:0] addrPinState = 2'h0;
    logic       addrBiasEn;
    logic [7:0] cfgWordFour = 8'h00;
    logic       cfgLoadDone = 1'b0;
    logic       powerOnRequestIn = 1'b0;
    logic       mainsSenseIn = 1'b0;
    logic       powerOnRequestOut;
    logic       mainsSenseOut;
    logic       eraseBusy;
    wire        sdaIn = sdaDrv & ~sdaOe; // Open drain, pulled up.
    int         err_count = 0;
    int         num_checks = 0;
    int         cycles = 0;
    logic [6:0] me;
    logic [3:0] acks;
    logic [7:0] rd0;
    logic [7:0] rd1;
    logic       rdAck;

    always #12.5 clk = ~clk;

    smbep_port #(.ERASE_CYCLES(ERASE)) i_smbep_port (
        .clk(clk), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(), .sdaOe(sdaOe),
        .addrPinState(addrPinState), .addrBiasEn(addrBiasEn), .cfgWordFour(cfgWordFour),
        .cfgLoadDone(cfgLoadDone), .powerOnRequestIn(powerOnRequestIn), .mainsSenseIn(mainsSenseIn),
        .powerOnRequestOut(powerOnRequestOut), .mainsSenseOut(mainsSenseOut), .eraseBusy(eraseBusy)
    );
    smbep_master_model i_smbep_master_model (.clk(clk), .sclOut(sclIn), .sdaDrv(sdaDrv), .sdaWire(sdaIn));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (err_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Write n bytes, no stop; acks bit 0 is the address, bit k byte k.
    task automatic wrSeq(input logic [6:0] a, input logic [7:0] b0, b1, b2, input int n);
        logic       ak;
        i_smbep_master_model.cond(1'b1);
        i_smbep_master_model.byteX({a, 1'b0}, 1'b1, rd1, ak);
        acks = {3'h0, ak};
        for (int k = 0; k < n; k++) begin
            i_smbep_master_model.byteX(k == 0 ? b0 : (k == 1 ? b1 : b2), 1'b1, rd1, ak);
            acks[k + 1] = ak;
        end
    endtask

    // Read n bytes, the last without ack, then a stop.
    task automatic rdSeq(input logic [6:0] a, input int n);
        logic       ak;
        i_smbep_master_model.cond(1'b1);
        i_smbep_master_model.byteX({a, 1'b1}, 1'b1, rd1, rdAck);
        for (int k = 0; k < n; k++) begin
            i_smbep_master_model.byteX(8'hFF, k == n - 1, rd1, ak);
            if (k == 0)
                rd0 = rd1;
        end
        i_smbep_master_model.cond(1'b0);
    endtask

    // Pointer set by a write, then a repeated start and one byte read.
    task automatic readAt(input logic [7:0] hi, input logic [7:0] lo, input int n);
        wrSeq(me, hi, lo, 8'h00, n);
        rdSeq(me, 1);
    endtask

    task automatic wrStop(input logic [6:0] a, input logic [7:0] b0, b1, b2, input int n);
        wrSeq(a, b0, b1, b2, n);
        i_smbep_master_model.cond(1'b0);
    endtask

    // Float sets A2; extend sets A1, or A0 when floating.
    function automatic logic [6:0] devAddr(input logic ext, input logic [1:0] pin);
        return {4'hA, pin == 2'h2, ext & (pin != 2'h2), (pin == 2'h1) | (ext & (pin == 2'h2))};
    endfunction

    task automatic addrScan();
        check({7'h0, addrBiasEn}, 8'h01);
        for (int e = 0; e < 2; e++) begin
            @(posedge clk);
            cfgWordFour <= {6'h0, e[0], 1'b0};
            cfgLoadDone <= 1'b1;
            @(posedge clk);
            cfgLoadDone <= 1'b0;
            cfgWordFour <= {6'h0, ~e[0], 1'b0}; // Not latched: address stays.
            for (int p = 0; p < 3; p++) begin
                @(posedge clk);
                addrPinState <= p[1:0];
                repeat (4) @(posedge clk);
                me = devAddr(e[0], p[1:0]);
                wrStop(me ^ 7'h40, 8'h00, 8'h00, 8'h00, 0);
                check({4'h0, acks}, 8'h00);
                wrStop(me, 8'h00, 8'h00, 8'h00, 0);
                check({4'h0, acks}, 8'h01);
            end
        end
        check({7'h0, addrBiasEn}, 8'h00);
    endtask

    task automatic regRw();
        for (int k = 0; k < 2; k++) begin
            wrStop(me, k ? 8'h7F : 8'h00, k ? 8'h5A : 8'hA5, 8'h00, 2);
            check({4'h0, acks}, 8'h07);
            readAt(k ? 8'h7F : 8'h00, 8'h00, 1);
            check(rd0, k ? 8'h5A : 8'hA5);
        end
    endtask

    task automatic bcast();
        wrStop(7'h0C, 8'h06, 8'h3C, 8'h00, 2);
        check({4'h0, acks}, 8'h07);
        rdSeq(7'h0C, 1);
        check({7'h0, rdAck}, 8'h00);
        readAt(8'h06, 8'h00, 1);
        check(rd0, 8'h3C);
    endtask

    task automatic eeprom();
        wrStop(me, 8'h81, 8'h23, 8'h3C, 3);
        check({4'h0, acks}, 8'h0F);
        wrStop(me, 8'h81, 8'h40, 8'h77, 3);
        wrStop(me, 8'h81, 8'h23, 8'h55, 3);
        readAt(8'h81, 8'h23, 2);
        check(rd0, 8'h3C);
        wrStop(me, 8'hA2, 8'h81, 8'h3F, 3);
        check({4'h0, acks}, 8'h0F);
        check({7'h0, eraseBusy}, 8'h01);
        wrStop(me, 8'h80, 8'h00, 8'h00, 2);
        check({6'h0, acks[1:0]}, 8'h01);
        while (eraseBusy)
            @(posedge clk);
        readAt(8'h81, 8'h23, 2);
        check(rd0, 8'hFF);
        readAt(8'h81, 8'h40, 2);
        check(rd0, 8'h77);
        wrStop(me, 8'h81, 8'h23, 8'h55, 3);
        readAt(8'h81, 8'h23, 2);
        check(rd0, 8'h55);
    endtask

    task automatic blockRead();
        wrStop(me, 8'h7F, 8'h00, 8'h00, 1);
        wrSeq(me, 8'hA1, 8'h00, 8'h00, 1);
        rdSeq(me, 2);
        check(rd0, 8'h01);
        check(rd1, 8'h5A);
    endtask

    task automatic breakPath();
        @(posedge clk);
        powerOnRequestIn <= 1'b1;
        repeat (5) @(posedge clk);
        check({6'h0, powerOnRequestOut, mainsSenseOut}, 8'h02);
        wrStop(me, 8'h41, 8'h02, 8'h00, 2);
        wrStop(me, 8'h40, 8'h03, 8'h00, 2);
        check({6'h0, powerOnRequestOut, mainsSenseOut}, 8'h01);
        readAt(8'h42, 8'h00, 1);
        check({6'h0, rd0[1:0]}, 8'h01);
        wrStop(me, 8'h40, 8'h00, 8'h00, 2);
        repeat (5) @(posedge clk);
        check({6'h0, powerOnRequestOut, mainsSenseOut}, 8'h02);
    endtask

    // Three reset cycles, a synchroniser pause, then the scenarios.
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        addrScan();
        regRw();
        bcast();
        eeprom();
        blockRead();
        breakPath();
        results();
    end

    // Cuts a hang short; scenarios need far less.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_count++;
            results();
        end
    end
endmodule // tb
`default_nettype wire
